/* File: hdl/flash_device_end.sv */
// Operation
// - Identity address has A[4:0] and A6 zero.
// - Identity read twice or more, last valid.
// - Flash returns fixed code, mask returns array.
// - Status readable in operation, then back to read.
// - Status read at target address, A[1:0] zero.
// - Upper sixteen data bits read zero while busy.
// - Programming: bit seven reads complement of data.
// - Erasing: bit seven zero, then one.
// - Failure freezes bit seven; check limit flag too.
// - Polling valid after last command write.
// - Bit five sets when time limit exceeded.
// - Programming one over zero halts, then fails.
// - After failure only software reset unlocks.
// - Block erase opens 50 us window first.
// - Bit three zero in window, one erasing.
// - Each block erase restarts the window.
// - Bit three one after any failure.
// - Ready clears on last write, or window end.
// - Commands ignored while ready bit is zero, except reset after failure.
// - Version bit: flash zero, mask one, rest fixed.
// - Register accessed as whole words, zeros written.
// - After failed erase, issue reset to recover.
//
// Register access over AHB-Lite was decided locally.
`timescale 1ns/100ps
`include "flash_status_map.svh"
module flash_device_end
    import flash_status_pkg::*;
#(
    parameter logic [15:0] WIN_CYCLES   = 16'(`WIN_CYC),
    parameter logic [15:0] PROG_CYCLES  = 16'(`PROG_CYC),
    parameter logic [15:0] ERASE_CYCLES = 16'(`ERASE_CYC),
    parameter logic [15:0] LIMIT_CYCLES = 16'(`LIMIT_CYC),
    parameter logic        MASK_VERSION = 1'b0,
    parameter logic [15:0] ID_CODE      = 16'h0042 // Arbitrary value.
) (
    input  wire logic  clk,
    input  wire logic  resetn,
    flash_link_if.dev  link,
    input  wire logic  fault_inject,
    output logic       ready_out
);
    logic [31:0] mem [64];
    dev_state_e  state;
    dev_state_e  next_state;
    logic [15:0] cnt;
    logic [15:0] target;
    logic [1:0]  blk_sel;
    logic [5:0]  prog_idx;
    logic [31:0] prog_val;
    logic        fail_pend;
    logic        data_poll_flag;
    logic        timing_limit_flag;
    logic        erase_window_flag;
    logic        ready_busy_flag;
    logic        aw;
    logic        csr_hit;
    logic        done;
    logic        restart;
    logic        embedded;
    logic [5:0]  widx;
    logic [1:0]  blk_hit;
    logic [31:0] flash_ctl_status_reg;

    // A command write to the array at the given address and data.
    function automatic logic cyc(input logic [15:0] a, input logic [7:0] d);
        return aw && link.addr[15:0] == a && link.wdata[7:0] == d;
    endfunction

    // Bus decode; register writes are not command cycles.
    assign csr_hit  = link.addr == `FLASH_CONTROL_STATUS_ADDR;
    assign aw       = link.req && link.we && !csr_hit;
    assign widx     = link.addr[7:2];
    assign blk_hit  = link.addr[7] ? 2'b10 : 2'b01;
    assign embedded = state inside {S_WIN, S_BPROG, S_BERASE, S_FAIL};
    assign done     = cnt == target - 16'd1;
    assign restart  = state == S_WIN && aw;
    assign ready_out = ready_busy_flag;

    // Duration of the current timed state; a pending failure runs to limit.
    always_comb begin
        if (state == S_WIN) begin
            target = WIN_CYCLES;
        end else if (fail_pend) begin
            target = LIMIT_CYCLES;
        end else if (state == S_BPROG) begin
            target = PROG_CYCLES;
        end else begin
            target = ERASE_CYCLES;
        end
    end

    // Command sequencer. Busy states take no command but the unlock reset.
    always_comb begin
        next_state = state;
        unique case (state)
            S_READ:   if (cyc(`UNLK_A1, `UNLK_D1)) next_state = S_UNL1;
            S_UNL1:   if (aw) next_state = cyc(`UNLK_A2, `UNLK_D2) ? S_UNL2
                                                                   : S_READ;
            S_UNL2: begin
                if (cyc(`UNLK_A1, `CMD_PROG)) begin
                    next_state = S_PROG;
                end else if (cyc(`UNLK_A1, `CMD_ERASE)) begin
                    next_state = S_ER4;
                end else if (cyc(`UNLK_A1, `CMD_IDREAD)) begin
                    next_state = S_ID;
                end else if (aw) begin
                    next_state = S_READ;
                end
            end
            S_PROG:   if (aw) next_state = S_BPROG;
            S_ER4:    if (aw) next_state = cyc(`UNLK_A1, `UNLK_D1) ? S_ER5
                                                                   : S_READ;
            S_ER5:    if (aw) next_state = cyc(`UNLK_A2, `UNLK_D2) ? S_ER6
                                                                   : S_READ;
            S_ER6: begin
                if (cyc(`UNLK_A1, `CMD_CHIP)) begin
                    next_state = S_BERASE;
                end else if (aw && link.wdata[7:0] == `CMD_BLOCK) begin
                    next_state = S_WIN;
                end else if (aw) begin
                    next_state = S_READ;
                end
            end
            S_ID:     if (aw && link.wdata[7:0] == `CMD_RESET) begin
                next_state = S_READ;
            end
            S_WIN: begin
                if (aw) begin
                    next_state = link.wdata[7:0] == `CMD_BLOCK ? S_WIN
                                                               : S_READ;
                end else if (done) begin
                    next_state = S_BERASE;
                end
            end
            S_BPROG, S_BERASE: begin
                if (done) next_state = fail_pend ? S_FAIL : S_READ;
            end
            S_FAIL:   if (aw && link.wdata[7:0] == `CMD_RESET) begin
                next_state = S_READ;
            end
        endcase
    end

    // State register.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state <= S_READ;
        end else begin
            state <= next_state;
        end
    end

    // Cycle counter for window, algorithm and limit; restarts on each entry.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cnt <= 16'h0000;
        end else if (next_state != state || restart) begin
            cnt <= 16'h0000;
        end else begin
            cnt <= cnt + 16'd1;
        end
    end

    // Target capture. Programming a one over a zero can never succeed, so
    // it is marked failing at once and left to run out the limit.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            fail_pend <= 1'b0;
            prog_idx  <= 6'h00;
            prog_val  <= 32'h00000000;
            blk_sel   <= 2'b00;
        end else if (state == S_PROG && next_state == S_BPROG) begin
            prog_idx  <= widx;
            prog_val  <= link.wdata;
            fail_pend <= |(~mem[widx] & link.wdata);
        end else if (state == S_ER6 && next_state == S_WIN) begin
            blk_sel   <= blk_hit;
            fail_pend <= 1'b0;
        end else if (state == S_ER6 && next_state == S_BERASE) begin
            blk_sel   <= 2'b11;
            fail_pend <= 1'b0;
        end else if (restart && next_state == S_WIN) begin
            blk_sel   <= blk_sel | blk_hit;
        end else if (state inside {S_BPROG, S_BERASE}) begin
            fail_pend <= fail_pend | fault_inject;
        end
    end

    // Array. Erased cells hold all ones; completed algorithms update it.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            for (int i = 0; i < 64; i++) mem[i] <= 32'hffffffff;
        end else if (done && !fail_pend && state == S_BPROG) begin
            mem[prog_idx] <= prog_val;
        end else if (done && !fail_pend && state == S_BERASE) begin
            for (int i = 0; i < 64; i++) begin
                if (blk_sel[i / 32]) mem[i] <= 32'hffffffff;
            end
        end
    end

    // Status flags; each is updated on the edge that enters the state that it reports.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            data_poll_flag    <= 1'b0;
            timing_limit_flag <= 1'b0;
            erase_window_flag <= 1'b0;
            ready_busy_flag   <= 1'b1;
        end else begin
            ready_busy_flag <= !(next_state inside
                                 {S_BPROG, S_BERASE, S_FAIL});
            if (state == S_PROG && next_state == S_BPROG) begin
                data_poll_flag <= ~link.wdata[`DQ7_POS];
            end else if (state == S_ER6 && next_state != S_READ) begin
                data_poll_flag <= 1'b0;
            end
            if (next_state == S_FAIL) begin
                timing_limit_flag <= 1'b1;
                erase_window_flag <= 1'b1;
            end else if (next_state == S_BERASE) begin
                erase_window_flag <= 1'b1;
            end else if (next_state != state) begin
                timing_limit_flag <= 1'b0;
                erase_window_flag <= 1'b0;
            end
        end
    end

    // Register view: only ready and version bits; the mask part is fixed.
    always_comb begin
        flash_ctl_status_reg = 32'h00000000;
        flash_ctl_status_reg[`MV_POS] = MASK_VERSION;
        flash_ctl_status_reg[`RB_POS] = MASK_VERSION | ready_busy_flag;
    end

    // Read answer one cycle after the request. Undefined status bits are
    // driven as zero so that the answer is deterministic.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            link.ack   <= 1'b0;
            link.rdata <= 32'h00000000;
        end else begin
            link.ack <= link.req;
            if (csr_hit) begin
                link.rdata <= flash_ctl_status_reg;
            end else if (embedded) begin
                link.rdata <= 32'h00000000;
                link.rdata[`DQ7_POS] <= data_poll_flag;
                link.rdata[`DQ5_POS] <= timing_limit_flag;
                link.rdata[`DQ3_POS] <= erase_window_flag;
            end else if (state == S_ID && !MASK_VERSION) begin
                link.rdata <= {16'h0000, ID_CODE};
            end else begin
                link.rdata <= mem[widx];
            end
        end
    end
endmodule

/* File: hdl/flash_status_map.svh */
`ifndef FLASH_STATUS_MAP_SVH
`define FLASH_STATUS_MAP_SVH
// Control/status register and its fields.
`define FLASH_CONTROL_STATUS_ADDR       32'hffffe520
`define FLASH_CONTROL_STATUS_WR_ZERO    32'h00000092
`define RB_POS          2
`define MV_POS          3
// Status bit positions in a data word read during an embedded operation.
`define DQ7_POS         7
`define DQ5_POS         5
`define DQ3_POS         3
// Command cycle addresses and data.
`define UNLK_A1         16'h5554
`define UNLK_A2         16'haaa8
`define UNLK_D1         8'haa
`define UNLK_D2         8'h55
`define CMD_RESET       8'hf0
`define CMD_PROG        8'ha0
`define CMD_ERASE       8'h80
`define CMD_CHIP        8'h10
`define CMD_BLOCK       8'h30
`define CMD_IDREAD      8'h90
// Address masks for identification and status reads.
`define ID_ADDR_MASK    32'hffffffa0
`define STAT_ADDR_MASK  32'hfffffffc
// Timing: clock rate, erase window and internal algorithm durations.
`define CLK_MHZ         200
`define WIN_US          50
`define WIN_CYC         (`WIN_US * `CLK_MHZ)
`define PROG_CYC        64
`define ERASE_CYC       256
`define LIMIT_CYC       512
// Controller register offsets.
`define REG_CMD_ADDR    8'h00
`define REG_CMD_DATA    8'h04
`define REG_CTRL        8'h08
`define REG_STAT        8'h0c
`define REG_RDATA       8'h10
`endif

/* File: hdl/flash_status_pkg.sv */
package flash_status_pkg;
    typedef enum {
        S_READ, S_UNL1, S_UNL2, S_PROG, S_ER4, S_ER5, S_ER6,
        S_ID, S_WIN, S_BPROG, S_BERASE, S_FAIL
    } dev_state_e;
    typedef enum logic [1:0] {OP_WRITE, OP_READ, OP_IDENT, OP_POLL} host_op_e;
    typedef enum {H_IDLE, H_ISSUE, H_WAIT} host_state_e;
    typedef struct packed {
        logic        we;
        logic [31:0] addr;
        logic [31:0] data;
        logic        last;
    } step_s;
endpackage

/* File: hdl/flash_link_if.sv */
`timescale 1ns/100ps
// One bus cycle per req pulse; the device answers with ack a cycle later.
interface flash_link_if;
    logic        req;
    logic        we;
    logic [31:0] addr;
    logic [31:0] wdata;
    logic [31:0] rdata;
    logic        ack;
    modport dev  (input req, we, addr, wdata, output rdata, ack);
    modport host (output req, we, addr, wdata, input rdata, ack);
endinterface

/* File: hdl/flash_host_end.sv */
`timescale 1ns/100ps
`include "flash_status_map.svh"
module flash_host_end
    import flash_status_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        resetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic [31:0]      hrdata,
    output logic             hresp,
    flash_link_if.host       link
);
    logic [31:0] cmd_addr;
    logic [31:0] cmd_data;
    logic [31:0] read_data;
    host_op_e    op;
    host_state_e hstate;
    logic [2:0]  step;
    logic        busy;
    logic        poll_fail;
    logic        take;
    logic        wr_pend;
    logic        rd_pend;
    logic [7:0]  a_off;
    logic        start;
    step_s       cur;

    // Register read decode; unmapped offsets read zero.
    function automatic logic [31:0] reg_read(input logic [7:0] off);
        unique case (off)
            `REG_CMD_ADDR: return cmd_addr;
            `REG_CMD_DATA: return cmd_data;
            `REG_CTRL:     return {30'h0, op};
            `REG_STAT:     return {30'h0, poll_fail, busy};
            `REG_RDATA:    return read_data;
            default:       return 32'h00000000;
        endcase
    endfunction

    // Link cycle for one step of an operation.
    function automatic step_s step_of(input host_op_e o, input logic [2:0] s,
                                      input logic [31:0] a,
                                      input logic [31:0] d);
        step_s r;
        r = '0;
        unique case (o)
            OP_WRITE: begin
                r = '{1'b1, a, d, 1'b1};
                if (a == `FLASH_CONTROL_STATUS_ADDR) r.data = d & ~`FLASH_CONTROL_STATUS_WR_ZERO;
            end
            OP_READ:  r = '{1'b0, a & `STAT_ADDR_MASK, 32'h0, 1'b1};
            OP_IDENT: begin
                unique case (s)
                    3'd0: r = '{1'b1, {a[31:16], `UNLK_A1},
                                {24'h0, `UNLK_D1}, 1'b0};
                    3'd1: r = '{1'b1, {a[31:16], `UNLK_A2},
                                {24'h0, `UNLK_D2}, 1'b0};
                    3'd2: r = '{1'b1, {a[31:16], `UNLK_A1},
                                {24'h0, `CMD_IDREAD}, 1'b0};
                    default: r = '{1'b0, a & `ID_ADDR_MASK, 32'h0,
                                   s == 3'd4};
                endcase
            end
            OP_POLL: begin
                if (s == 3'd0) begin
                    r = '{1'b0, a & `STAT_ADDR_MASK, 32'h0, 1'b0};
                end else begin
                    r = '{1'b1, a, {24'h0, `CMD_RESET}, 1'b1};
                end
            end
        endcase
        return r;
    endfunction

    assign take  = hsel && htrans[1] && hready;
    assign start = wr_pend && a_off == `REG_CTRL && !busy;
    assign cur   = step_of(op, step, cmd_addr, cmd_data);

    // Bus slave: writes answer at once, reads take one wait state so the
    // read sees a write in the data phase just before it.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            wr_pend   <= 1'b0;
            rd_pend   <= 1'b0;
            a_off     <= 8'h00;
            hreadyout <= 1'b1;
            hrdata    <= 32'h00000000;
            hresp     <= 1'b0;
        end else begin
            wr_pend   <= take && hwrite;
            rd_pend   <= take && !hwrite;
            hreadyout <= !(take && !hwrite);
            if (take) a_off <= haddr[7:0];
            if (rd_pend) hrdata <= reg_read(a_off);
        end
    end

    // Command registers; frozen while an operation runs.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cmd_addr <= 32'h00000000;
            cmd_data <= 32'h00000000;
        end else if (wr_pend && !busy) begin
            if (a_off == `REG_CMD_ADDR) cmd_addr <= hwdata;
            if (a_off == `REG_CMD_DATA) cmd_data <= hwdata;
        end
    end

    // Operation sequencer on the link.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            hstate     <= H_IDLE;
            op         <= OP_WRITE;
            step       <= 3'd0;
            busy       <= 1'b0;
            poll_fail  <= 1'b0;
            read_data  <= 32'h00000000;
            link.req   <= 1'b0;
            link.we    <= 1'b0;
            link.addr  <= 32'h00000000;
            link.wdata <= 32'h00000000;
        end else begin
            link.req <= 1'b0;
            unique case (hstate)
                H_IDLE: if (start) begin
                    op        <= host_op_e'(hwdata[1:0]);
                    step      <= 3'd0;
                    busy      <= 1'b1;
                    poll_fail <= 1'b0;
                    hstate    <= H_ISSUE;
                end
                H_ISSUE: begin
                    link.req   <= 1'b1;
                    link.we    <= cur.we;
                    link.addr  <= cur.addr;
                    link.wdata <= cur.data;
                    hstate     <= H_WAIT;
                end
                H_WAIT: if (link.ack) begin
                    if (!cur.we) read_data <= link.rdata;
                    hstate <= H_ISSUE;
                    if (op == OP_POLL && step == 3'd0) begin
                        // Done once bit seven matches; limit flag aborts.
                        if (link.rdata[`DQ7_POS] == cmd_data[`DQ7_POS]) begin
                            busy   <= 1'b0;
                            hstate <= H_IDLE;
                        end else if (link.rdata[`DQ5_POS]) begin
                            poll_fail <= 1'b1;
                            step      <= 3'd1;
                        end
                    end else if (cur.last) begin
                        busy   <= 1'b0;
                        hstate <= H_IDLE;
                    end else begin
                        step <= step + 3'd1;
                    end
                end
            endcase
        end
    end
endmodule

/* File: tb/flash_link_monitor.sv */
`timescale 1ns/100ps
`include "flash_status_map.svh"
module flash_link_monitor #(
    parameter int          LIMIT_CYCLES = 100,
    parameter int          WIN_CYCLES   = 30,
    parameter logic [15:0] ID_CODE      = 16'h0042 // Arbitrary value.
) (
    input wire logic        clk,
    input wire logic        resetn,
    input wire logic        req,
    input wire logic        we,
    input wire logic [31:0] addr,
    input wire logic [31:0] wdata,
    input wire logic [31:0] rdata,
    input wire logic        ack,
    input wire logic        ready_out
);
    localparam int LIM4 = LIMIT_CYCLES + 4;
    localparam int HALF = LIMIT_CYCLES / 2;
    logic       prog_arm, prog_busy, pd7, id_mode, er_arm, er_win;
    logic [7:0] busy_cnt, win_cnt;
    logic       wr_cmd, rd_stat, blk_wr;
    // Decoded link traffic.
    assign wr_cmd  = req && we && addr[15:0] == `UNLK_A1 && ready_out;
    assign rd_stat = req && !we && !ready_out && addr != `FLASH_CONTROL_STATUS_ADDR;
    assign blk_wr  = req && we && wdata[7:0] == `CMD_BLOCK;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    // Track the running command for status checks.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            prog_arm  <= 1'b0;
            prog_busy <= 1'b0;
            pd7       <= 1'b0;
            id_mode   <= 1'b0;
            er_arm    <= 1'b0;
            er_win    <= 1'b0;
        end else begin
            if (req && we)
                prog_arm <= wr_cmd && wdata[7:0] == `CMD_PROG;
            if (prog_arm && req && we)
                prog_busy <= 1'b1;
            else if (ready_out)
                prog_busy <= 1'b0;
            if (prog_arm && req && we)
                pd7 <= wdata[7];
            if (wr_cmd && wdata[7:0] == `CMD_IDREAD)
                id_mode <= 1'b1;
            else if (req && we && wdata[7:0] == `CMD_RESET)
                id_mode <= 1'b0;
            if (wr_cmd && wdata[7:0] == `CMD_ERASE)
                er_arm <= 1'b1;
            else if (!ready_out)
                er_arm <= 1'b0;
            if (er_arm && blk_wr)
                er_win <= 1'b1;
            else if (!ready_out)
                er_win <= 1'b0;
        end
    end
    // Saturating counters; window count restarts per block write.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            busy_cnt <= 8'h00;
            win_cnt  <= 8'h00;
        end else begin
            busy_cnt <= ready_out ? 8'h00 : busy_cnt + 8'(busy_cnt != 8'hff);
            win_cnt  <= blk_wr ? 8'h00 : win_cnt + 8'(win_cnt != 8'hff);
        end
    end
    sequence id_enter;
        req && we && addr[15:0] == `UNLK_A1 && wdata[7:0] == `CMD_IDREAD;
    endsequence
    sequence id_fetch;
        req && !we && addr[4:0] == 5'h00 && !addr[6];
    endsequence
    a_ack_timing: assert property (
        ack == $past(req)) else $error("Ack late.");
    a_csr_fixed: assert property (
        $past(req && !we && !id_mode && addr == `FLASH_CONTROL_STATUS_ADDR)
        |-> (rdata & 32'hfffffffb) == 32'h0) else $error("Bad CSR bits.");
    a_csr_wr_zero: assert property (
        req && we && addr == `FLASH_CONTROL_STATUS_ADDR |-> (wdata & `FLASH_CONTROL_STATUS_WR_ZERO) == 0)
        else $error("CSR write sets reserved bits.");
    a_id_reads: assert property (
        id_enter ##1 ack |-> ##[1:4] id_fetch ##[2:4] id_fetch)
        else $error("Identity reads wrong.");
    a_id_code: assert property (
        $past(req && !we && id_mode) |-> rdata == {16'h0, ID_CODE})
        else $error("Wrong identity code.");
    a_prog_busy: assert property (
        prog_arm && req && we |=> !ready_out [*3])
        else $error("Ready not cleared.");
    a_busy_upper: assert property (
        $past(rd_stat) |-> rdata[31:8] == 24'h0 && !rdata[6] && !rdata[4])
        else $error("Busy upper bits.");
    a_prog_poll: assert property (
        $past(rd_stat && prog_busy) |-> rdata[7] == !pd7
        && rdata[3] == rdata[5]) else $error("Bad program status.");
    a_erase_poll: assert property (
        $past(rd_stat && !prog_busy) |-> !rdata[7] && rdata[3])
        else $error("Bad erase status.");
    a_limit_flag: assert property (
        $past(rd_stat) && ($past(busy_cnt) < HALF || $past(busy_cnt) > LIM4)
        |-> rdata[5] == ($past(busy_cnt) > LIM4))
        else $error("Time limit flag wrong.");
    a_locked_fail: assert property (
        busy_cnt > LIM4 && !ready_out
        && !(req && we && wdata[7:0] == `CMD_RESET)
        |=> !ready_out) else $error("Left failed state.");
    a_window_len: assert property (
        $fell(ready_out) && er_win |-> win_cnt >= WIN_CYCLES - 3
        && win_cnt <= WIN_CYCLES + 1) else $error("Erase window length.");
endmodule

/* File: tb/tb.sv */
`timescale 1ns/100ps
`include "flash_status_map.svh"
module tb;
    localparam logic [15:0] ID_VAL = 16'h5a3c; // Arbitrary value.
    logic        clk, resetn, hsel, hwrite, hreadyout, hresp;
    logic        fault_inject, ready_out;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [31:0] haddr, hwdata, hrdata, rd, s, d, d0, p, rnd;
    int          miscompares, cmp_count;
    flash_link_if link();
    // Host end drives the device over the link.
    flash_host_end u_flash_host_end (.clk(clk), .resetn(resetn),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
        .link(link));
    flash_device_end #(.WIN_CYCLES(16'd30), .PROG_CYCLES(16'd40),
        .ERASE_CYCLES(16'd40), .LIMIT_CYCLES(16'd100),
        .ID_CODE(ID_VAL)) u_flash_device_end (
        .clk(clk), .resetn(resetn), .link(link),
        .fault_inject(fault_inject), .ready_out(ready_out));
    flash_link_monitor #(.ID_CODE(ID_VAL)) u_flash_link_monitor (.clk(clk),
        .resetn(resetn), .req(link.req), .we(link.we), .addr(link.addr),
        .wdata(link.wdata), .rdata(link.rdata), .ack(link.ack),
        .ready_out(ready_out));
    function automatic logic [31:0] lfsr_next(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    // Status of a program locked after its limit.
    function automatic logic [31:0] fail_exp(input logic [31:0] w);
        return {24'h0, ~w[7], 7'b0101000};
    endfunction
    // One word transfer, held until hready is sampled.
    task automatic ahb(input logic w, input logic [7:0] o,
                       input logic [31:0] wd, output logic [31:0] r);
        haddr  <= {24'h0, o};
        hwrite <= w;
        hsel   <= 1'b1;
        htrans <= 2'b10;
        do @(posedge clk); while (hreadyout !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        do @(posedge clk); while (hreadyout !== 1'b1);
        r = hrdata;
    endtask
    // Run one link operation and fetch its data.
    task automatic op(input logic [1:0] c, input logic [31:0] a,
                      input logic [31:0] v);
        ahb(1'b1, `REG_CMD_ADDR, a, s);
        ahb(1'b1, `REG_CMD_DATA, v, s);
        ahb(1'b1, `REG_CTRL, {30'h0, c}, s);
        do ahb(1'b0, `REG_STAT, 32'h0, s); while (s[0] !== 1'b0);
        ahb(1'b0, `REG_RDATA, 32'h0, rd);
    endtask
    task automatic unlock();
        op(2'd0, {16'h0, `UNLK_A1}, 32'haa);
        op(2'd0, {16'h0, `UNLK_A2}, 32'h55);
    endtask
    task automatic cmd(input logic [7:0] c);
        unlock();
        op(2'd0, {16'h0, `UNLK_A1}, {24'h0, c});
    endtask
    // Register word check; only ready may vary.
    task automatic csr(input logic r);
        op(2'd1, `FLASH_CONTROL_STATUS_ADDR, 32'h0);
        chk(rd, {29'h0, r, 2'b00});
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH %0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic final_report();
        if (miscompares == 0 && cmp_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    // Watchdog for a hung handshake.
    initial begin
        repeat (20000) @(posedge clk);
        miscompares++;
        final_report();
    end
    // Main sequence.
    initial begin
        resetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'b010;
        hwdata = 32'h0;
        fault_inject = 1'b0;
        miscompares = 0;
        cmp_count = 0;
        rnd = 32'heba8;
        repeat (5) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
        csr(1'b1);
        op(2'd0, `FLASH_CONTROL_STATUS_ADDR, 32'hffffffff);
        csr(1'b1);
        for (int i = 0; i < 3; i++) begin
            rnd = lfsr_next(rnd);
            d = rnd & 32'hfffffffe;
            if (i == 0)
                d0 = d;
            p = 32'(i * 64 + 4);
            cmd(8'ha0);
            op(2'd0, p, d);
            op(2'd3, p, d);
            chk(rd, d);
            op(2'd1, p, 32'h0);
            chk(rd, d);
        end
        d = d0 | 32'h1;
        cmd(8'ha0);
        op(2'd0, 32'h4, d);
        repeat (120) @(posedge clk);
        csr(1'b0);
        op(2'd1, 32'h4, 32'h0);
        chk(rd, fail_exp(d));
        unlock();
        csr(1'b0);
        op(2'd0, 32'h0, 32'hf0);
        csr(1'b1);
        cmd(8'h80);
        unlock();
        op(2'd0, 32'h0, 32'h30);
        op(2'd0, 32'h80, 32'h30);
        op(2'd3, 32'h4, 32'h80);
        chk(rd, 32'hffffffff);
        op(2'd1, 32'h84, 32'h0);
        chk(rd, 32'hffffffff);
        fault_inject <= 1'b1;
        cmd(8'h80);
        cmd(8'h10);
        op(2'd3, 32'h0, 32'h80);
        fault_inject <= 1'b0;
        ahb(1'b0, `REG_STAT, 32'h0, s);
        chk(s, 32'h2);
        csr(1'b1);
        rnd = lfsr_next(rnd);
        op(2'd2, rnd, 32'h0);
        chk(rd, {16'h0, ID_VAL});
        rnd = lfsr_next(rnd);
        ahb(1'b1, 8'h20, rnd, s);
        ahb(1'b0, 8'h20, 32'h0, s);
        chk(s, 32'h0);
        final_report();
    end
endmodule
